// ### inc/quad_port_pkg.sv
// constants shared by the quad parallel port block and its input filter
package quad_port_pkg;

   localparam int          PORT_W          = 8;

   // port selector used on the write and read strobes
   localparam logic [1:0]  SEL_ADDR_DATA   = 2'h0;
   localparam logic [1:0]  SEL_ANALOG      = 2'h1;
   localparam logic [1:0]  SEL_UPPER       = 2'h2;
   localparam logic [1:0]  SEL_ALT         = 2'h3;

   // latch values
   localparam logic [7:0]  LATCH_RESET     = 8'hFF;
   localparam logic [7:0]  ALL_ONES        = 8'hFF;
   localparam logic [7:0]  ALL_ZEROS       = 8'h00;

   // analog-capable port bit positions
   localparam int          BIT_TMR2_COUNT  = 0;
   localparam int          BIT_TMR2_TRIG   = 1;
   localparam int          BIT_SPI_SS      = 5;

   // upper address port bits taken by the pwm outputs
   localparam int          BIT_UP_PWM0     = 6;
   localparam int          BIT_UP_PWM1     = 7;

   // alternate function port bit positions
   localparam int          BIT_RXD         = 0;
   localparam int          BIT_TXD         = 1;
   localparam int          BIT_IRQ0        = 2;
   localparam int          BIT_IRQ1        = 3;
   localparam int          BIT_MOSI        = 3;
   localparam int          BIT_ALT_PWM1    = 3;
   localparam int          BIT_TMR0        = 4;
   localparam int          BIT_ALT_PWM0    = 4;
   localparam int          BIT_TMR1        = 5;
   localparam int          BIT_WR          = 6;
   localparam int          BIT_RD          = 7;

   // input conditioning
   localparam int          SYNC_W          = 34;
   localparam int          CLK_PERIOD_NS   = 100;
   localparam int          GLITCH_NS       = 50;
   localparam int          GLITCH_CYCLES   = ((GLITCH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS < 1)
                                             ? 1
                                             : (GLITCH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int          PIN_FILT_CYCLES = 0;
   localparam int          FILT_CW         = 2;

endpackage : quad_port_pkg

// ### rtl/pin_sync_filter.sv
// three-stage input synchroniser with optional glitch rejection
`timescale 1ns/1ps
module pin_sync_filter #(
   parameter int             W           = 1,
   parameter int             FILT_CYCLES = 0,
   parameter int             CW          = 2,
   parameter logic [W-1:0]   INIT        = '0
) (
   // clock and reset
   input  wire logic         clk,
   input  wire logic         rst_n,
   // raw and conditioned levels
   input  wire logic [W-1:0] pin_in,
   output logic      [W-1:0] level
);
   import quad_port_pkg::*;

   localparam logic [CW-1:0] LIMIT = CW'(FILT_CYCLES);
   localparam logic [CW-1:0] ONE   = CW'(1);

   typedef struct packed {
      logic [W-1:0]         s1;
      logic [W-1:0]         s2;
      logic [W-1:0]         s3;
      logic [W-1:0]         out;
      logic [W-1:0][CW-1:0] cnt;
   } filt_s;

   filt_s st;
   filt_s next_st;

   always_comb begin
      next_st    = st;
      next_st.s1 = pin_in;
      next_st.s2 = st.s1;
      next_st.s3 = st.s2;
      for (int i = 0; i < W; i++) begin
         // a change counts only while the second and third stage agree
         if ((st.s2[i] == st.s3[i]) && (st.s3[i] != st.out[i])) begin
            if (st.cnt[i] == LIMIT) begin
               next_st.out[i] = st.s3[i];
               next_st.cnt[i] = '0;
            end else begin
               next_st.cnt[i] = st.cnt[i] + ONE;
            end
         end else begin
            next_st.cnt[i] = '0;
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         st.s1  <= INIT;
         st.s2  <= INIT;
         st.s3  <= INIT;
         st.out <= INIT;
         st.cnt <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign level = st.out;

   // a new level needs FILT_CYCLES+1 cycles of agreement before it is taken
   chk_glitch_reject: assert property (@(posedge clk) disable iff (!rst_n)
      (st.out != $past(st.out)) |-> ((FILT_CYCLES == 0) ||
      (((st.out ^ $past(st.out)) & ($past(st.s3, 2) ^ $past(st.s3))) == '0)))
      else $error("filtered level changed after a too short pulse");

endmodule : pin_sync_filter

// ### rtl/quad_parallel_io_ports.sv
// four 8-bit parallel ports with memory bus, pwm, alternate and serial pin muxing
`timescale 1ns/1ps
// Functional notes
// - first port is eight open-drain latched pins
// - read-latch returns latch, read-pin returns pins
// - first port carries low address/data bus
// - external access loads ones into first latch
// - external access drives first port push-pull
// - first port latch one floats, zero drives low
// - second port never drives its pins
// - second port resets to analog, zero selects digital
// - second port feeds timer2 and spi select
// - third port outputs high address bytes
// - third port drives address, latch kept unchanged
// - third/fourth port latch one weak high, zero low
// - pwm replaces third port bits six, seven
// - fourth port alternates pass only with latch one
// - fourth port alternate function assignment per bit
// - pwm replaces fourth port bits three, four
// - mosi shares fourth port bit three
// - i2c weak pull-up only, spi push-pull drive
// - i2c inputs reject short glitches
// - software drives serial pins in i2c master
// - enabled peripheral takes its pin from gpio
// - read-modify-write reads the latch
module quad_parallel_io_ports (
   // clock and reset
   input  wire logic        CLK,
   input  wire logic        RESET_N,
   // cpu port access
   input  wire logic        WR_EN,
   input  wire logic [1:0]  WR_SEL,
   input  wire logic [7:0]  WR_DATA,
   input  wire logic        RD_EN,
   input  wire logic [1:0]  RD_SEL,
   input  wire logic        RD_LATCH,
   input  wire logic        RMW_READ,
   output logic      [7:0]  RD_DATA,
   output logic             RD_VALID,
   // external memory bus
   input  wire logic        XMEM_ACTIVE,
   input  wire logic        XMEM_AD_DRIVE,
   input  wire logic [7:0]  XMEM_AD_OUT,
   input  wire logic [7:0]  XMEM_ADDR_HI,
   output logic      [7:0]  XMEM_AD_IN,
   // first port pins
   input  wire logic [7:0]  AD_PIN_I,
   output logic      [7:0]  AD_PIN_O,
   output logic      [7:0]  AD_PIN_OE,
   // second port pins
   input  wire logic [7:0]  ANALOG_PIN_I,
   output logic      [7:0]  ANALOG_SEL,
   // third port pins
   input  wire logic [7:0]  UPPER_PIN_I,
   output logic      [7:0]  UPPER_PIN_O,
   output logic      [7:0]  UPPER_PIN_OE,
   // fourth port pins and peripheral outputs
   input  wire logic [7:0]  ALT_PIN_I,
   output logic      [7:0]  ALT_PIN_O,
   output logic      [7:0]  ALT_PIN_OE,
   input  wire logic [7:0]  ALT_FUNC_EN,
   input  wire logic [7:0]  ALT_FUNC_OUT,
   input  wire logic        MOSI_ON_ALT,
   input  wire logic        SPI_MOSI_OUT,
   // pwm
   input  wire logic        PWM_UPPER_EN,
   input  wire logic        PWM_ALT_EN,
   input  wire logic        PWM0_OUT,
   input  wire logic        PWM1_OUT,
   // peripheral inputs from the ports
   output logic             TIMER2_COUNT_INPUT,
   output logic             TIMER2_CAPTURE_TRIGGER,
   output logic             SPI_SS_N_IN,
   output logic             UART_RXD_IN,
   output logic             EXT_IRQ_ZERO,
   output logic             EXT_IRQ_ONE,
   output logic             SPI_MISO_IN,
   output logic             TIMER0_COUNT_INPUT,
   output logic             TIMER1_COUNT_INPUT,
   // serial clock and data pins
   input  wire logic        SERIAL_PERIPH_SELECT,
   input  wire logic        SPI_SCLK_OUT,
   input  wire logic        SPI_SCLK_DRIVE,
   input  wire logic        SPI_DATA_OUT,
   input  wire logic        SPI_DATA_DRIVE,
   input  wire logic        I2C_SCL_OUT,
   input  wire logic        I2C_SDA_OUT,
   input  wire logic        I2C_SW_EN,
   input  wire logic        I2C_SW_SCL,
   input  wire logic        I2C_SW_SDA,
   input  wire logic        SERIAL_CLOCK_PIN_I,
   output logic             SERIAL_CLOCK_PIN_O,
   output logic             SERIAL_CLOCK_PIN_OE,
   input  wire logic        SERIAL_DATA_PIN_I,
   output logic             SERIAL_DATA_PIN_O,
   output logic             SERIAL_DATA_PIN_OE,
   output logic             SERIAL_WEAK_PULLUP,
   output logic             SPI_SCLK_IN,
   output logic             SPI_DATA_IN,
   output logic             I2C_SCL_IN,
   output logic             I2C_SDA_IN
);
   import quad_port_pkg::*;

   typedef struct packed {
      logic [7:0] port_zero_latch_reg;
      logic [7:0] analog_input_port_reg;
      logic [7:0] upper_address_port_reg;
      logic [7:0] alternate_function_port_reg;
      logic [7:0] rd_data;
      logic       rd_valid;
      logic [7:0] xmem_ad_in;
      logic [7:0] ad_o;
      logic [7:0] ad_oe;
      logic [7:0] up_o;
      logic [7:0] up_oe;
      logic [7:0] alt_o;
      logic [7:0] alt_oe;
      logic       sc_o;
      logic       sc_oe;
      logic       sd_o;
      logic       sd_oe;
      logic       weak_pu;
   } port_s;

   port_s              st;
   port_s              next_st;
   logic               rst_meta;
   logic               rst_n;
   logic [SYNC_W-1:0]  sync_level;
   logic [7:0]         lvl_ad;
   logic [7:0]         lvl_an;
   logic [7:0]         lvl_up;
   logic [7:0]         lvl_alt;
   logic               lvl_sc;
   logic               lvl_sd;
   logic [1:0]         i2c_level;

   function automatic logic [7:0] pick_port(input logic [1:0] sel, input logic [7:0] a,
                                            input logic [7:0] b, input logic [7:0] c,
                                            input logic [7:0] d);
      case (sel)
         SEL_ADDR_DATA: pick_port = a;
         SEL_ANALOG:    pick_port = b;
         SEL_UPPER:     pick_port = c;
         default:       pick_port = d;
      endcase
   endfunction : pick_port

   // reset release through two flops
   always_ff @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         rst_meta <= 1'b0;
         rst_n    <= 1'b0;
      end else begin
         rst_meta <= 1'b1;
         rst_n    <= rst_meta;
      end
   end

   // every pin level seen by the core passes the synchroniser
   pin_sync_filter #(
      .W           (SYNC_W),
      .FILT_CYCLES (PIN_FILT_CYCLES),
      .CW          (FILT_CW),
      .INIT        ({SYNC_W{1'b0}})
   ) u_pin_sync (
      .clk    (CLK),
      .rst_n  (rst_n),
      .pin_in ({SERIAL_DATA_PIN_I, SERIAL_CLOCK_PIN_I, ALT_PIN_I, UPPER_PIN_I,
                ANALOG_PIN_I, AD_PIN_I}),
      .level  (sync_level)
   );

   // i2c inputs get their own glitch filter, idle high
   pin_sync_filter #(
      .W           (2),
      .FILT_CYCLES (GLITCH_CYCLES),
      .CW          (FILT_CW),
      .INIT        (2'h3)
   ) u_i2c_filt (
      .clk    (CLK),
      .rst_n  (rst_n),
      .pin_in ({SERIAL_DATA_PIN_I, SERIAL_CLOCK_PIN_I}),
      .level  (i2c_level)
   );

   assign {lvl_sd, lvl_sc, lvl_alt, lvl_up, lvl_an, lvl_ad} = sync_level;

   always_comb begin
      logic [7:0] up_eff;
      logic [7:0] alt_src;
      logic [7:0] alt_eff;
      logic       sc_lvl;
      logic       sd_lvl;
      up_eff  = '0;
      alt_src = '0;
      alt_eff = '0;
      sc_lvl  = 1'b0;
      sd_lvl  = 1'b0;
      next_st = st;

      // latch writes
      if (WR_EN) begin
         case (WR_SEL)
            SEL_ADDR_DATA: next_st.port_zero_latch_reg         = WR_DATA;
            SEL_ANALOG:    next_st.analog_input_port_reg       = WR_DATA;
            SEL_UPPER:     next_st.upper_address_port_reg      = WR_DATA;
            default:       next_st.alternate_function_port_reg = WR_DATA;
         endcase
      end
      if (XMEM_ACTIVE) begin
         next_st.port_zero_latch_reg = ALL_ONES;
      end

      // reads: latch for latch and read-modify-write cycles, else pins
      next_st.rd_valid = RD_EN;
      if (RD_EN) begin
         if (RD_LATCH || RMW_READ) begin
            next_st.rd_data = pick_port(RD_SEL, st.port_zero_latch_reg,
                                        st.analog_input_port_reg, st.upper_address_port_reg,
                                        st.alternate_function_port_reg);
         end else begin
            next_st.rd_data = pick_port(RD_SEL, lvl_ad, lvl_an, lvl_up, lvl_alt);
         end
      end
      next_st.xmem_ad_in = lvl_ad;

      // first port: bus push-pull or open drain
      if (XMEM_ACTIVE) begin
         next_st.ad_o  = XMEM_AD_OUT;
         next_st.ad_oe = XMEM_AD_DRIVE ? ALL_ONES : ALL_ZEROS;
      end else begin
         next_st.ad_o  = ALL_ZEROS;
         next_st.ad_oe = ~st.port_zero_latch_reg;
      end

      // third port: address drive leaves the latch alone
      up_eff = st.upper_address_port_reg;
      if (PWM_UPPER_EN) begin
         up_eff[BIT_UP_PWM0] = PWM0_OUT;
         up_eff[BIT_UP_PWM1] = PWM1_OUT;
      end
      if (XMEM_ACTIVE) begin
         next_st.up_o  = XMEM_ADDR_HI;
         next_st.up_oe = ALL_ONES;
      end else begin
         next_st.up_o  = ALL_ZEROS;
         next_st.up_oe = ~up_eff;
      end

      // fourth port: peripheral output gated by its latch bit
      alt_src = ALT_FUNC_OUT;
      if (MOSI_ON_ALT) begin
         alt_src[BIT_MOSI] = SPI_MOSI_OUT;
      end
      alt_eff = st.alternate_function_port_reg & (alt_src | ~ALT_FUNC_EN);
      if (PWM_ALT_EN) begin
         alt_eff[BIT_ALT_PWM1] = PWM1_OUT;
         alt_eff[BIT_ALT_PWM0] = PWM0_OUT;
      end
      next_st.alt_o  = ALL_ZEROS;
      next_st.alt_oe = ~alt_eff;

      // serial pins
      if (SERIAL_PERIPH_SELECT) begin
         next_st.sc_o    = SPI_SCLK_OUT;
         next_st.sc_oe   = SPI_SCLK_DRIVE;
         next_st.sd_o    = SPI_DATA_OUT;
         next_st.sd_oe   = SPI_DATA_DRIVE;
         next_st.weak_pu = 1'b0;
      end else begin
         sc_lvl          = I2C_SW_EN ? I2C_SW_SCL : I2C_SCL_OUT;
         sd_lvl          = I2C_SW_EN ? I2C_SW_SDA : I2C_SDA_OUT;
         next_st.sc_o    = 1'b0;
         next_st.sc_oe   = ~sc_lvl;
         next_st.sd_o    = 1'b0;
         next_st.sd_oe   = ~sd_lvl;
         next_st.weak_pu = 1'b1;
      end
   end

   always_ff @(posedge CLK or negedge rst_n) begin
      if (!rst_n) begin
         st                             <= '0;
         st.port_zero_latch_reg         <= LATCH_RESET;
         st.analog_input_port_reg       <= LATCH_RESET;
         st.upper_address_port_reg      <= LATCH_RESET;
         st.alternate_function_port_reg <= LATCH_RESET;
         st.weak_pu                     <= 1'b1;
      end else begin
         st <= next_st;
      end
   end

   // outputs; the second port has no drive at all
   assign RD_DATA                = st.rd_data;
   assign RD_VALID               = st.rd_valid;
   assign XMEM_AD_IN             = st.xmem_ad_in;
   assign AD_PIN_O               = st.ad_o;
   assign AD_PIN_OE              = st.ad_oe;
   assign ANALOG_SEL             = st.analog_input_port_reg;
   assign UPPER_PIN_O            = st.up_o;
   assign UPPER_PIN_OE           = st.up_oe;
   assign ALT_PIN_O              = st.alt_o;
   assign ALT_PIN_OE             = st.alt_oe;
   assign SERIAL_CLOCK_PIN_O     = st.sc_o;
   assign SERIAL_CLOCK_PIN_OE    = st.sc_oe;
   assign SERIAL_DATA_PIN_O      = st.sd_o;
   assign SERIAL_DATA_PIN_OE     = st.sd_oe;
   assign SERIAL_WEAK_PULLUP     = st.weak_pu;
   assign TIMER2_COUNT_INPUT     = lvl_an[BIT_TMR2_COUNT];
   assign TIMER2_CAPTURE_TRIGGER = lvl_an[BIT_TMR2_TRIG];
   assign SPI_SS_N_IN            = lvl_an[BIT_SPI_SS];
   assign UART_RXD_IN            = lvl_alt[BIT_RXD];
   assign EXT_IRQ_ZERO           = lvl_alt[BIT_IRQ0];
   assign EXT_IRQ_ONE            = lvl_alt[BIT_IRQ1];
   assign SPI_MISO_IN            = lvl_alt[BIT_IRQ1];
   assign TIMER0_COUNT_INPUT     = lvl_alt[BIT_TMR0];
   assign TIMER1_COUNT_INPUT     = lvl_alt[BIT_TMR1];
   assign SPI_SCLK_IN            = lvl_sc;
   assign SPI_DATA_IN            = lvl_sd;
   assign I2C_SCL_IN             = i2c_level[0];
   assign I2C_SDA_IN             = i2c_level[1];

   chk_xmem_ones: assert property (@(posedge CLK) disable iff (!rst_n)
      XMEM_ACTIVE |=> (st.port_zero_latch_reg == ALL_ONES))
      else $error("first port latch not all ones during external access");

   chk_ad_pushpull: assert property (@(posedge CLK) disable iff (!rst_n)
      (XMEM_ACTIVE && XMEM_AD_DRIVE) |=> (AD_PIN_OE == ALL_ONES) && (AD_PIN_O == $past(XMEM_AD_OUT)))
      else $error("first port not driving the bus push-pull");

   chk_ad_opendrain: assert property (@(posedge CLK) disable iff (!rst_n)
      !XMEM_ACTIVE |=> (AD_PIN_O == ALL_ZEROS) && (AD_PIN_OE == ~$past(st.port_zero_latch_reg)))
      else $error("first port open-drain drive wrong");

   chk_read_latch: assert property (@(posedge CLK) disable iff (!rst_n)
      (RD_EN && (RD_LATCH || RMW_READ) && (RD_SEL == SEL_UPPER))
      |=> RD_VALID && (RD_DATA == $past(st.upper_address_port_reg)))
      else $error("latch read returned wrong data");

   chk_upper_hold: assert property (@(posedge CLK) disable iff (!rst_n)
      (XMEM_ACTIVE && !(WR_EN && (WR_SEL == SEL_UPPER)))
      |=> $stable(st.upper_address_port_reg) && (UPPER_PIN_OE == ALL_ONES))
      else $error("third port latch changed or not driven during addressing");

   chk_pwm_upper: assert property (@(posedge CLK) disable iff (!rst_n)
      (PWM_UPPER_EN && !XMEM_ACTIVE) |=> (UPPER_PIN_OE[BIT_UP_PWM1] == !$past(PWM1_OUT)))
      else $error("pwm not replacing third port bit");

   chk_alt_gate: assert property (@(posedge CLK) disable iff (!rst_n)
      !PWM_ALT_EN |=> ((ALT_PIN_OE | $past(st.alternate_function_port_reg)) == ALL_ONES))
      else $error("alternate function passed a zero latch");

   chk_analog_reset: assert property (@(posedge CLK)
      $rose(rst_n) |-> (ANALOG_SEL == LATCH_RESET))
      else $error("second port latch not analog after reset");

   chk_i2c_weak: assert property (@(posedge CLK) disable iff (!rst_n)
      !SERIAL_PERIPH_SELECT |=> !SERIAL_CLOCK_PIN_O && !SERIAL_DATA_PIN_O && SERIAL_WEAK_PULLUP)
      else $error("serial pins driven high in i2c mode");

   chk_i2c_soft: assert property (@(posedge CLK) disable iff (!rst_n)
      (!SERIAL_PERIPH_SELECT && I2C_SW_EN) |=> (SERIAL_DATA_PIN_OE == !$past(I2C_SW_SDA)))
      else $error("software data level not on serial data pin");

endmodule : quad_parallel_io_ports

// ### test/pin_world.sv
// pin environment: external pull-ups and drivers resolved against the port drives
`timescale 1ns/1ps
module pin_world (
   // drives from the block
   input  wire logic [7:0] ad_o,
   input  wire logic [7:0] ad_oe,
   input  wire logic [7:0] up_o,
   input  wire logic [7:0] up_oe,
   input  wire logic [7:0] alt_o,
   input  wire logic [7:0] alt_oe,
   input  wire logic       sc_o,
   input  wire logic       sc_oe,
   input  wire logic       sd_o,
   input  wire logic       sd_oe,
   // external levels, all ones where only a pull-up holds the line
   input  wire logic [7:0] ext_ad,
   input  wire logic [7:0] ext_up,
   input  wire logic [7:0] ext_alt,
   input  wire logic       ext_sc,
   input  wire logic       ext_sd,
   // resolved pin levels
   output logic      [7:0] ad_i,
   output logic      [7:0] up_i,
   output logic      [7:0] alt_i,
   output logic            sc_i,
   output logic            sd_i
);
   // released lines go to the pull-up level, an external low wins
   assign ad_i  = (ad_o | ~ad_oe) & ext_ad;
   assign up_i  = (up_o | ~up_oe) & ext_up;
   assign alt_i = (alt_o | ~alt_oe) & ext_alt;
   assign sc_i  = (sc_o | ~sc_oe) & ext_sc;
   assign sd_i  = (sd_o | ~sd_oe) & ext_sd;
endmodule : pin_world

// ### test/quad_parallel_io_ports_tb.sv
// self-checking bench for the quad parallel port block
`timescale 1ns/1ps
module quad_parallel_io_ports_tb;
   import quad_port_pkg::*;
   logic       CLK, RESET_N, WR_EN, RD_EN, RD_LATCH, RMW_READ, XMEM_ACTIVE, XMEM_AD_DRIVE;
   logic       MOSI_ON_ALT, SPI_MOSI_OUT, PWM_UPPER_EN, PWM_ALT_EN, PWM0_OUT, PWM1_OUT;
   logic       SERIAL_PERIPH_SELECT, SPI_SCLK_OUT, SPI_SCLK_DRIVE, SPI_DATA_OUT;
   logic       SPI_DATA_DRIVE, I2C_SCL_OUT, I2C_SDA_OUT, I2C_SW_EN, I2C_SW_SCL, I2C_SW_SDA;
   logic       SERIAL_CLOCK_PIN_I, SERIAL_DATA_PIN_I, ext_sc, ext_sd;
   logic [1:0] WR_SEL, RD_SEL;
   logic [7:0] WR_DATA, XMEM_AD_OUT, XMEM_ADDR_HI, ANALOG_PIN_I, ALT_FUNC_EN, ALT_FUNC_OUT;
   logic [7:0] AD_PIN_I, UPPER_PIN_I, ALT_PIN_I, ext_ad, ext_up, ext_alt;
   logic [7:0] RD_DATA, XMEM_AD_IN, AD_PIN_O, AD_PIN_OE, ANALOG_SEL, UPPER_PIN_O;
   logic [7:0] UPPER_PIN_OE, ALT_PIN_O, ALT_PIN_OE;
   logic       RD_VALID, TIMER2_COUNT_INPUT, TIMER2_CAPTURE_TRIGGER, SPI_SS_N_IN, UART_RXD_IN;
   logic       EXT_IRQ_ZERO, EXT_IRQ_ONE, SPI_MISO_IN, TIMER0_COUNT_INPUT, TIMER1_COUNT_INPUT;
   logic       SERIAL_CLOCK_PIN_O, SERIAL_CLOCK_PIN_OE, SERIAL_DATA_PIN_O, SERIAL_DATA_PIN_OE;
   logic       SERIAL_WEAK_PULLUP, SPI_SCLK_IN, SPI_DATA_IN, I2C_SCL_IN, I2C_SDA_IN;
   int         err_total = 0;
   int         samples_checked = 0;

   quad_parallel_io_ports u_dut (.*);
   pin_world u_pins (.ad_o(AD_PIN_O), .ad_oe(AD_PIN_OE), .up_o(UPPER_PIN_O),
      .up_oe(UPPER_PIN_OE), .alt_o(ALT_PIN_O), .alt_oe(ALT_PIN_OE),
      .sc_o(SERIAL_CLOCK_PIN_O), .sc_oe(SERIAL_CLOCK_PIN_OE), .sd_o(SERIAL_DATA_PIN_O),
      .sd_oe(SERIAL_DATA_PIN_OE), .ext_ad(ext_ad), .ext_up(ext_up), .ext_alt(ext_alt),
      .ext_sc(ext_sc), .ext_sd(ext_sd), .ad_i(AD_PIN_I), .up_i(UPPER_PIN_I),
      .alt_i(ALT_PIN_I), .sc_i(SERIAL_CLOCK_PIN_I), .sd_i(SERIAL_DATA_PIN_I));

   always #50 CLK = ~CLK;

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      samples_checked++;
      if (got !== exp) begin
         err_total++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic tick(input int n);
      repeat (n) @(negedge CLK);
   endtask : tick

   // request held over one rising edge, then an idle edge before the next one
   task automatic wr(input logic [1:0] sel, input logic [7:0] d);
      WR_EN = 1'b1;
      WR_SEL = sel;
      WR_DATA = d;
      tick(1);
      WR_EN = 1'b0;
      tick(1);
   endtask : wr

   task automatic rd(input logic [1:0] sel, input logic lat, input logic rmw,
                     input logic [7:0] exp);
      RD_EN = 1'b1;
      RD_SEL = sel;
      RD_LATCH = lat;
      RMW_READ = rmw;
      tick(1);
      RD_EN = 1'b0;
      chk({7'h00, RD_VALID}, 8'h01);
      chk(RD_DATA, exp);
      tick(1);
   endtask : rd

   task automatic stop_test;
      $display("checks %0d mismatches %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : stop_test

   task automatic t_reset;
      chk(ANALOG_SEL, LATCH_RESET);
      chk(AD_PIN_OE, ALL_ZEROS);
      for (int s = 0; s < 4; s++) begin
         rd(s[1:0], 1'b1, 1'b0, LATCH_RESET);
      end
   endtask : t_reset

   task automatic t_first;
      ext_ad = 8'h0F;
      wr(SEL_ADDR_DATA, 8'h5A);
      chk(AD_PIN_OE, 8'hA5);
      chk(AD_PIN_I, 8'h0A);
      tick(6);
      rd(SEL_ADDR_DATA, 1'b0, 1'b0, 8'h0A);
      chk(XMEM_AD_IN, 8'h0A);
      rd(SEL_ADDR_DATA, 1'b1, 1'b0, 8'h5A);
      rd(SEL_ADDR_DATA, 1'b0, 1'b1, 8'h5A);
      ext_ad = ALL_ONES;
   endtask : t_first

   task automatic t_xmem;
      wr(SEL_UPPER, 8'h12);
      XMEM_AD_OUT = 8'h3C;
      XMEM_ADDR_HI = 8'hC3;
      XMEM_ACTIVE = 1'b1;
      XMEM_AD_DRIVE = 1'b1;
      tick(1);
      chk(AD_PIN_OE, ALL_ONES);
      chk(AD_PIN_O, 8'h3C);
      chk(UPPER_PIN_O, 8'hC3);
      chk(UPPER_PIN_OE, ALL_ONES);
      XMEM_AD_DRIVE = 1'b0;
      wr(SEL_ADDR_DATA, 8'h00);
      chk(AD_PIN_OE, ALL_ZEROS);
      XMEM_ACTIVE = 1'b0;
      tick(2);
      rd(SEL_ADDR_DATA, 1'b1, 1'b0, ALL_ONES);
      rd(SEL_UPPER, 1'b1, 1'b0, 8'h12);
      chk(UPPER_PIN_I, 8'h12);
      chk(AD_PIN_OE, ALL_ZEROS);
      PWM_UPPER_EN = 1'b1;
      PWM0_OUT = 1'b1;
      tick(2);
      chk(UPPER_PIN_I, 8'h52);
      PWM_UPPER_EN = 1'b0;
   endtask : t_xmem

   task automatic t_analog;
      wr(SEL_ANALOG, 8'h00);
      chk(ANALOG_SEL, ALL_ZEROS);
      ANALOG_PIN_I = 8'h23;
      tick(6);
      chk({5'h00, TIMER2_COUNT_INPUT, TIMER2_CAPTURE_TRIGGER, SPI_SS_N_IN}, 8'h07);
      rd(SEL_ANALOG, 1'b0, 1'b0, 8'h23);
   endtask : t_analog

   task automatic t_alt;
      wr(SEL_ALT, 8'hF0);
      chk(ALT_PIN_I, 8'hF0);
      ALT_FUNC_EN = 8'h02;
      wr(SEL_ALT, ALL_ONES);
      chk(ALT_PIN_I, 8'hFD);
      ALT_FUNC_OUT = 8'h02;
      wr(SEL_ALT, 8'hFD);
      chk(ALT_PIN_I, 8'hFD);
      PWM_ALT_EN = 1'b1;
      wr(SEL_ALT, 8'hEF);
      chk(ALT_PIN_I, 8'hF7);
      PWM_ALT_EN = 1'b0;
      MOSI_ON_ALT = 1'b1;
      ALT_FUNC_EN = 8'h0A;
      wr(SEL_ALT, ALL_ONES);
      chk(ALT_PIN_I, 8'hF7);
      MOSI_ON_ALT = 1'b0;
      ALT_FUNC_EN = 8'h00;
      ext_alt = 8'h3D;
      tick(6);
      chk({2'h0, UART_RXD_IN, EXT_IRQ_ZERO, EXT_IRQ_ONE, SPI_MISO_IN, TIMER0_COUNT_INPUT,
           TIMER1_COUNT_INPUT}, 8'h3F);
   endtask : t_alt

   task automatic t_serial;
      SERIAL_PERIPH_SELECT = 1'b1;
      {SPI_SCLK_DRIVE, SPI_DATA_DRIVE, SPI_DATA_OUT} = 3'h7;
      tick(2);
      chk({3'h0, SERIAL_WEAK_PULLUP, SERIAL_CLOCK_PIN_OE, SERIAL_CLOCK_PIN_O,
           SERIAL_DATA_PIN_OE, SERIAL_DATA_PIN_O}, 8'h0B);
      SERIAL_PERIPH_SELECT = 1'b0;
      {I2C_SCL_OUT, I2C_SDA_OUT, I2C_SW_EN, I2C_SW_SDA} = 4'hF;
      tick(2);
      chk({5'h00, SERIAL_WEAK_PULLUP, SERIAL_CLOCK_PIN_I, SERIAL_DATA_PIN_I}, 8'h05);
      I2C_SW_EN = 1'b0;
      tick(8);
      chk({5'h00, I2C_SCL_IN, SPI_SCLK_IN, SPI_DATA_IN}, 8'h07);
      ext_sd = 1'b0;
      tick(1);
      ext_sd = 1'b1;
      repeat (8) begin
         tick(1);
         chk({7'h00, I2C_SDA_IN}, 8'h01);
      end
      ext_sd = 1'b0;
      tick(8);
      chk({7'h00, I2C_SDA_IN}, 8'h00);
   endtask : t_serial

   initial begin
      {CLK, RESET_N, WR_EN, RD_EN, RD_LATCH, RMW_READ, XMEM_ACTIVE, XMEM_AD_DRIVE} = '0;
      {MOSI_ON_ALT, SPI_MOSI_OUT, PWM_UPPER_EN, PWM_ALT_EN, PWM0_OUT, PWM1_OUT} = '0;
      {SERIAL_PERIPH_SELECT, SPI_SCLK_OUT, SPI_SCLK_DRIVE, SPI_DATA_OUT} = '0;
      {SPI_DATA_DRIVE, I2C_SCL_OUT, I2C_SDA_OUT, I2C_SW_EN, I2C_SW_SCL, I2C_SW_SDA} = '0;
      {WR_SEL, RD_SEL, WR_DATA, XMEM_AD_OUT, XMEM_ADDR_HI, ANALOG_PIN_I} = '0;
      {ALT_FUNC_EN, ALT_FUNC_OUT} = '0;
      {ext_ad, ext_up, ext_alt, ext_sc, ext_sd} = '1;
      tick(10);
      RESET_N = 1'b1;
      tick(4);
      t_reset();
      t_first();
      t_xmem();
      t_analog();
      t_alt();
      t_serial();
      stop_test();
   end

   // bench needs about 105 cycles
   initial begin
      #(3000 * 100);
      err_total++;
      stop_test();
   end
endmodule : quad_parallel_io_ports_tb
